// >>> verilog/tier_pkg.sv
package tier_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_EVENT_FLAGS  = 8'h03;
    localparam logic [7:0] ADDR_EVENT_MASK   = 8'h04;
    localparam logic [7:0] ADDR_COND_STATUS  = 8'h05;
    localparam logic [7:0] ADDR_ENABLE_CTRL  = 8'h06;
    localparam logic [7:0] ADDR_STARTUP_DLY1 = 8'h07;

    // ****************************************
    // reset values and field layout
    // ****************************************
    localparam logic [4:0] RST_EVENT_FLAGS   = 5'h00;
    localparam logic [4:0] RST_EVENT_MASK    = 5'h13;
    localparam logic [7:0] RST_ENABLE_CTRL   = 8'h00;
    localparam logic [7:0] RST_STARTUP_DLY1  = 8'h00;
    localparam int         FLG_WATCHDOG      = 4;
    localparam int         FLG_UNDERVOLTAGE  = 3;
    localparam int         FLG_THERMAL       = 2;
    localparam int         FLG_HOT           = 1;
    localparam int         FLG_WARM          = 0;
    localparam int         DLY_UNIT_BIT      = 7;
    localparam int         DLY_CODE_MSB      = 4;
    localparam int         STATUS_W          = 4;
    localparam int         NUM_MASTERS       = 4;
    localparam int         NUM_SYNC          = 10;

    // ****************************************
    // timing
    // ****************************************
    localparam int         CLK_HZ            = 20_000_000;
    localparam int         DELAY_UNIT_MS     = 1;
    localparam int         CYCLES_PER_MS     = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam logic [5:0] SHORT_UNIT_MULT   = 6'h01;
    localparam logic [5:0] LONG_UNIT_MULT    = 6'h02;

    // ****************************************
    // master 2 start sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_COUNT = 2'b01,
        SEQ_ON    = 2'b11
    } tier_seq_t;

endpackage : tier_pkg

// >>> verilog/tier_top.sv
`timescale 1ns/1ps

module tier_top #(
    parameter int MS_CYCLES = tier_pkg::CYCLES_PER_MS
) (
    // clock, reset, enable
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic       CE,
    // register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // condition and control pins
    input  wire logic       WATCHDOG_INPUT_N,
    input  wire logic       UNDERVOLTAGE_IN,
    input  wire logic       THERMAL_SHUTDOWN_IN,
    input  wire logic       JUNCTION_HOT_IN,
    input  wire logic       JUNCTION_WARM_IN,
    input  wire logic       ENABLE_PIN,
    input  wire logic [3:0] GENERAL_PURPOSE_INPUT,
    input  wire logic       GLOBAL_ENABLE_BIT,
    // regulator control outputs
    output logic      [3:0] MASTER_OUTPUT_ENABLE,
    output logic      [3:0] MASTER_LOW_POWER_SELECT,
    output logic            MASTER2_POWER_UP,
    // interrupt
    output logic            IRQ_N
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int N = tier_pkg::NUM_SYNC;
    logic [N-1:0] s1_q, s2_q, s3_q, filt_q, filt_prev_q;
    wire  [N-1:0] pins_raw = {GENERAL_PURPOSE_INPUT, ENABLE_PIN, JUNCTION_WARM_IN,
                              JUNCTION_HOT_IN, THERMAL_SHUTDOWN_IN, UNDERVOLTAGE_IN,
                              WATCHDOG_INPUT_N};
    // a change only counts once stages two and three agree
    wire  [N-1:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            s1_q        <= 10'h001;
            s2_q        <= 10'h001;
            s3_q        <= 10'h001;
            filt_q      <= 10'h001;
            filt_prev_q <= 10'h001;
        end else if (CE) begin
            s1_q        <= pins_raw;
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            filt_q      <= filt_d;
            filt_prev_q <= filt_q;
        end
    end

    wire       wdt_n_s  = filt_q[0];
    wire [3:0] cond_s   = {filt_q[1], filt_q[2], filt_q[3], filt_q[4]};
    wire [3:0] cond_old = {filt_prev_q[1], filt_prev_q[2], filt_prev_q[3], filt_prev_q[4]};
    wire       en_pin_s = filt_q[5];
    wire [3:0] gpi_s    = filt_q[9:6];

    // ****************************************
    // register decode
    // ****************************************
    wire wr_mask  = REG_WR && (REG_ADDR == tier_pkg::ADDR_EVENT_MASK);
    wire wr_ctrl  = REG_WR && (REG_ADDR == tier_pkg::ADDR_ENABLE_CTRL);
    wire wr_dly   = REG_WR && (REG_ADDR == tier_pkg::ADDR_STARTUP_DLY1);
    wire rd_flags = REG_RD && (REG_ADDR == tier_pkg::ADDR_EVENT_FLAGS);

    // ****************************************
    // event flags and mask
    // ****************************************
    logic [4:0] flags_q, mask_q;
    logic [7:0] ctrl_q, dly_q, rdata_q;
    wire  wdt_event = filt_prev_q[0] && !wdt_n_s;
    wire  [4:0] events = {wdt_event, cond_s & ~cond_old};
    // a set arriving with the read-clear survives into the next read
    wire  [4:0] flags_d = (rd_flags ? 5'h00 : flags_q) | events;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            flags_q <= tier_pkg::RST_EVENT_FLAGS;
            mask_q  <= tier_pkg::RST_EVENT_MASK;
            ctrl_q  <= tier_pkg::RST_ENABLE_CTRL;
            dly_q   <= tier_pkg::RST_STARTUP_DLY1;
        end else if (CE) begin
            flags_q <= flags_d;
            if (wr_mask) begin
                mask_q <= REG_WDATA[4:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= REG_WDATA;
            end
            if (wr_dly) begin
                dly_q <= {REG_WDATA[7], 2'b00, REG_WDATA[4:0]};
            end
        end
    end

    wire [4:0] pending = flags_q & ~mask_q;
    assign IRQ_N = ~(|pending);

    // ****************************************
    // read path
    // ****************************************
    // status has no reset of its own: it follows the synchronised pins
    wire [7:0] status_v = {4'h0, cond_s};
    wire [7:0] rd_mux =
        (REG_ADDR == tier_pkg::ADDR_EVENT_FLAGS)  ? {3'b000, flags_q} :
        (REG_ADDR == tier_pkg::ADDR_EVENT_MASK)   ? {3'b000, mask_q}  :
        (REG_ADDR == tier_pkg::ADDR_COND_STATUS)  ? status_v          :
        (REG_ADDR == tier_pkg::ADDR_ENABLE_CTRL)  ? ctrl_q            :
        (REG_ADDR == tier_pkg::ADDR_STARTUP_DLY1) ? dly_q             : 8'h00;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rdata_q <= 8'h00;
        end else if (CE && REG_RD) begin
            rdata_q <= rd_mux;
        end
    end
    assign REG_RDATA = rdata_q;

    // ****************************************
    // master enables and low power selects
    // ****************************************
    logic [3:0] men_q, lpm_q;
    wire  [3:0] men_d = {ctrl_q[6], ctrl_q[4], ctrl_q[2], ctrl_q[0]} | gpi_s;
    wire  [3:0] lpm_d = {ctrl_q[7], ctrl_q[5], ctrl_q[3], ctrl_q[1]};

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            men_q <= 4'h0;
            lpm_q <= 4'h0;
        end else if (CE) begin
            men_q <= men_d;
            lpm_q <= lpm_d;
        end
    end
    assign MASTER_OUTPUT_ENABLE    = men_q;
    assign MASTER_LOW_POWER_SELECT = lpm_q;

    // ****************************************
    // master 2 start delay
    // ****************************************
    localparam int             PRE_W   = $clog2(MS_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(MS_CYCLES - 1);

    tier_pkg::tier_seq_t seq_q, seq_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [5:0]       units_q, units_d;
    logic             en_all_prev_q;
    wire  en_all  = en_pin_s || GLOBAL_ENABLE_BIT;
    wire  en_rise = en_all && !en_all_prev_q;
    wire  [5:0] mult  = dly_q[tier_pkg::DLY_UNIT_BIT] ? tier_pkg::LONG_UNIT_MULT
                                                      : tier_pkg::SHORT_UNIT_MULT;
    wire  [5:0] total = 6'({1'b0, dly_q[tier_pkg::DLY_CODE_MSB:0]} * mult);
    wire  ms_tick = (pre_q == PRE_MAX);

    always_comb begin
        seq_d   = seq_q;
        pre_d   = pre_q;
        units_d = units_q;
        unique case (seq_q)
            tier_pkg::SEQ_IDLE: begin
                pre_d   = '0;
                units_d = total;
                if (en_rise) begin
                    seq_d = (total == 6'h00) ? tier_pkg::SEQ_ON : tier_pkg::SEQ_COUNT;
                end
            end
            tier_pkg::SEQ_COUNT: begin
                pre_d = ms_tick ? '0 : pre_q + 1'b1;
                if (ms_tick) begin
                    units_d = units_q - 6'h01;
                    if (units_q == 6'h01) begin
                        seq_d = tier_pkg::SEQ_ON;
                    end
                end
            end
            tier_pkg::SEQ_ON: begin
                pre_d = '0;
            end
            default: begin
                seq_d = tier_pkg::SEQ_IDLE;
            end
        endcase
        // dropping the enable abandons any delay in progress
        if (!en_all) begin
            seq_d = tier_pkg::SEQ_IDLE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            seq_q         <= tier_pkg::SEQ_IDLE;
            pre_q         <= '0;
            units_q       <= 6'h00;
            en_all_prev_q <= 1'b0;
        end else if (CE) begin
            seq_q         <= seq_d;
            pre_q         <= pre_d;
            units_q       <= units_d;
            en_all_prev_q <= en_all;
        end
    end
    assign MASTER2_POWER_UP = (seq_q == tier_pkg::SEQ_ON);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    chk_flag_read_clear: assert property (CE && rd_flags && events == 5'h00 |=> flags_q == 5'h00)
        else $error("flags not cleared by read");
    chk_watchdog_flag_set: assert property (CE && wdt_event |=> flags_q[4])
        else $error("watchdog flag not set");
    chk_thermal_flag_set: assert property (CE && cond_s[2] && !cond_old[2] |=> flags_q[2])
        else $error("thermal flag not set");
    chk_hot_flag_hold: assert property (CE && flags_q[1] && !rd_flags |=> flags_q[1])
        else $error("hot flag lost without read");
    chk_mask_after_reset: assert property (disable iff (1'b0)
        $past(RST) && !RST |-> mask_q == 5'h13)
        else $error("mask reset value wrong");
    chk_irq_masked: assert property (flags_q == 5'h04 && mask_q[2] |-> IRQ_N)
        else $error("interrupt asserted with the thermal flag masked");
    chk_irq_unmasked: assert property (flags_q[2] && !mask_q[2] |-> !IRQ_N)
        else $error("interrupt missing for an unmasked thermal flag");
    chk_status_live: assert property (CE && REG_RD
        && REG_ADDR == tier_pkg::ADDR_COND_STATUS |=> REG_RDATA == {4'h0, $past(cond_s)})
        else $error("status read does not match live conditions");
    chk_enable_or: assert property (CE |=> MASTER_OUTPUT_ENABLE ==
        $past({ctrl_q[6], ctrl_q[4], ctrl_q[2], ctrl_q[0]} | gpi_s))
        else $error("master enable not ctrl or gpi");
    chk_zero_delay_start: assert property (CE && seq_q == tier_pkg::SEQ_IDLE
        && en_rise && total == 6'h00 |=> MASTER2_POWER_UP)
        else $error("zero delay did not start at once");
    chk_delay_not_early: assert property (CE && seq_q == tier_pkg::SEQ_IDLE
        && en_rise && total != 6'h00 |=> !MASTER2_POWER_UP [*2])
        else $error("delayed start came too early");

endmodule : tier_top

// >>> verification/tier_host.sv
`timescale 1ns/1ps

// ****************************************
// host side of the register port
// ****************************************
module tier_host (
    // clock
    input  wire logic       clk,
    // register strobes
    output logic      [7:0] addr,
    output logic            wr,
    output logic      [7:0] wdata,
    output logic            rd
);
    initial begin
        addr  = 8'h00;
        wr    = 1'b0;
        wdata = 8'h00;
        rd    = 1'b0;
    end

    // strobes stand for exactly one edge, so each access is taken once
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
    endtask : read_reg
endmodule : tier_host

// >>> verification/testbench.sv
`timescale 1ns/1ps

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    localparam int MS = 4;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd;
    logic       rd_seen = 1'b0;
    logic [4:0] cond = 5'h00;
    logic       en_pin = 1'b0;
    logic       glb = 1'b0;
    logic [3:0] gpi = 4'h0;
    logic [3:0] moe, lps;
    logic       pwr, irq_n;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;
    logic       ce = 1'b1;
    int         num_errors = 0;
    int         n_tests = 0;

    always #25 clk = ~clk;

    tier_host tier_host_inst (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd));

    tier_top #(.MS_CYCLES(MS)) tier_top_inst (
        .CLK_SYS(clk), .RST(rst), .CE(ce), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata),
        .WATCHDOG_INPUT_N(~cond[4]), .UNDERVOLTAGE_IN(cond[3]),
        .THERMAL_SHUTDOWN_IN(cond[2]), .JUNCTION_HOT_IN(cond[1]),
        .JUNCTION_WARM_IN(cond[0]), .ENABLE_PIN(en_pin), .GENERAL_PURPOSE_INPUT(gpi),
        .GLOBAL_ENABLE_BIT(glb), .MASTER_OUTPUT_ENABLE(moe),
        .MASTER_LOW_POWER_SELECT(lps), .MASTER2_POWER_UP(pwr), .IRQ_N(irq_n));

    // ****************************************
    // read data watcher: one edge after each read
    // ****************************************
    always @(posedge clk) begin
        if (rd_seen) begin
            // take the note once, so a mismatch report cannot pop a second one
            exp_v = exp_q.pop_front();
            `CHK(rdata, exp_v)
        end
        rd_seen <= rd;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        tier_host_inst.read_reg(a);
    endtask : rd_exp

    // ****************************************
    // main sequence
    // ****************************************
    initial begin : main
        logic [7:0] r, m;
        int         n, e;
        void'($urandom(18));
        cyc(2);
        rst <= 1'b0;
        rd_exp(8'h03, 8'h00);
        rd_exp(8'h04, 8'h13);
        rd_exp(8'h06, 8'h00);
        rd_exp(8'h07, 8'h00);
        rd_exp(8'h1f, 8'h00);
        @(negedge clk);
        `CHK(irq_n, 1'b1)
        $display("test reset_values done");
        // one condition at a time, random mask, flag clears on the first read only
        for (int i = 0; i < 5; i++) begin
            m = 8'($urandom);
            tier_host_inst.write_reg(8'h04, m);
            rd_exp(8'h04, {3'h0, m[4:0]});
            @(posedge clk);
            cond <= 5'(1 << i);
            cyc(8);
            @(negedge clk);
            `CHK(irq_n, m[i])
            rd_exp(8'h05, (i < 4) ? 8'(1 << i) : 8'h00);
            rd_exp(8'h03, 8'(1 << i));
            rd_exp(8'h03, 8'h00);
            cyc(1);
            @(negedge clk);
            `CHK(irq_n, 1'b1)
            @(posedge clk);
            cond <= 5'h00;
            cyc(8);
        end
        $display("test event_flags done");
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            @(posedge clk);
            gpi <= 4'($urandom);
            tier_host_inst.write_reg(8'h06, r);
            cyc(5);
            @(negedge clk);
            `CHK(moe, {r[6], r[4], r[2], r[0]} | gpi)
            `CHK(lps, {r[7], r[5], r[3], r[1]})
            rd_exp(8'h06, r);
        end
        $display("test enables done");
        // a write while the clock enable is low must leave the register alone
        @(posedge clk);
        ce <= 1'b0;
        tier_host_inst.write_reg(8'h06, ~r);
        ce <= 1'b1;
        rd_exp(8'h06, r);
        $display("test clock_enable done");
        // code 0 by global bit, code 3 by pin, code 3 with the long unit
        for (int k = 0; k < 3; k++) begin
            r = {k[1], 2'($urandom), (k == 0) ? 5'h00 : 5'h03};
            tier_host_inst.write_reg(8'h07, r);
            rd_exp(8'h07, r & 8'h9f);
            @(posedge clk);
            if (k == 1) en_pin <= 1'b1;
            else glb <= 1'b1;
            e = int'(r[4:0]) * (r[7] ? 2 : 1) * MS;
            n = 0;
            while (pwr !== 1'b1 && n < 400) begin
                @(negedge clk);
                n++;
            end
            if (n >= 400) begin
                num_errors++;
                report_and_stop();
            end
            // two edges to start, and the pin path adds four synchroniser edges
            `CHK(n, e + ((k == 1) ? 6 : 2))
            @(posedge clk);
            en_pin <= 1'b0;
            glb    <= 1'b0;
            cyc(6);
            @(negedge clk);
            `CHK(pwr, 1'b0)
        end
        $display("test start_delay done");
        cyc(3);
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
endmodule : testbench
